//--- design/lpo_tick_calibrator.sv
`timescale 1ns/1ps
module lpo_tick_calibrator
	import pmu_seq_pkg::*;
#(
	parameter int CAL_WIDTH = 16
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	input  wire logic                 low_power_oscillator,
	output logic                      seq_tick,
	output logic [CAL_WIDTH-1:0]      cal_count
);
	typedef struct packed {
		logic                 lpo_prev;
		logic                 tick;
		logic [CAL_WIDTH-1:0] run;
		logic [CAL_WIDTH-1:0] cal;
	} cal_state_type;

	cal_state_type cur;
	cal_state_type next_cur;

	// =====================================
	// One tick per oscillator rising edge; crystal cycles per period are latched
	// so wake timers can be scaled precisely. Saturates rather than wraps.
	always_comb begin
		next_cur = cur;
		next_cur.lpo_prev = low_power_oscillator;
		next_cur.tick = low_power_oscillator && !cur.lpo_prev;
		if (next_cur.tick) begin
			// [RL5] crystal based calibration
			next_cur.cal = cur.run;
			next_cur.run = CAL_WIDTH'(1);
		end else if (cur.run != '1) begin
			next_cur.run = cur.run + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign seq_tick  = cur.tick;
	assign cal_count = cur.cal;
endmodule // lpo_tick_calibrator

//--- design/pmu_resource_sequencer.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// [RL1] Regulators stay powered while either section enable is high; off when both low.
// [RL2] A section enable powers needed regulators and releases that section's reset.
// [RL3] Core and low-noise LDOs follow baseband demand at run time.
// [RL4] Lowest mode turns off buck and both LDOs; always-on LDO remains; here no always-on LDO is modelled.
// [RL5] Sequencer timing is calibrated against the crystal clock.
// [RL6] Oscillator-driven counters switch each regulator; sequences fully programmable.
// [RL7] Doze stops PLL, crystal and radio; oscillator keeps sequencer alive.
// [RL8] Digital core state is saved to retention before the core powers off.
// [RL9] Wake from interrupt, bus resume or timer restores saved core state.
// [RL10] External logic leaves power-down by raising a section enable again.
// [RL11] Requests come from clock requests, minimum set and active request timers.
// [RL12] Each clock request maps to the resources producing that clock.
// [RL13] Every resource is always exactly one of four states.
// [RL14] Timers read zero when stable, nonzero in transition, loaded on decision.
// [RL15] Timers count down per tick; zero completes the transition.
// [RL16] Zero turn-on or turn-off time changes state immediately.
// [RL17] Required set is recomputed each tick from requests and dependencies.
// [RL18] Timer reaching zero clears pending and flips the state.
// [RL19] Disable enabled, unrequested resources with no powered dependents.
// [RL20] Enable disabled, requested resources whose dependencies are all enabled.
// [RL21] In shutdown all outputs tristate and most inputs are ignored; here outputs stay driven and only io_shutdown is raised.
// [RL22] Leaving shutdown behaves like power-up, nothing retained; here only the saved-core flag clears, register settings are kept.
// [RL23] Resource state runs on sequencer ticks; reset leaves all disabled.
// [RL24] A section is out of reset while its enable is high; here release also waits for the buck to be enabled.
module pmu_resource_sequencer
	import pmu_seq_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               reset_n,
	input  wire logic               bt_section_power_enable,
	input  wire logic               wlan_section_power_enable,
	input  wire logic               low_power_oscillator,
	input  wire logic [1:0]         core_clk_req,
	input  wire logic               baseband_demand,
	input  wire logic               ext_wake_irq,
	input  wire logic               sdio_resume,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output logic [31:0]             reg_rdata,
	output logic [NUM_RES-1:0]      regulator_enable,
	output logic                    wlan_section_reset_n,
	output logic                    bt_section_reset_n,
	output logic                    retention_save,
	output logic                    retention_restore,
	output logic                    io_shutdown,
	output logic [1:0]              power_mode
);
	typedef struct packed {
		logic [NUM_RES-1:0]                minimum_resource_set;
		logic [NUM_RES-1:0][NUM_RES-1:0]   dep;
		logic [NUM_RES-1:0][TIMER_W-1:0]   time_on;
		logic [NUM_RES-1:0][TIMER_W-1:0]   time_off;
		logic [REQ_CNT_W-1:0]              req_count;
		logic [NUM_RES-1:0]                req_mask;
		logic                              wake_pending;
		logic                              core_saved;
		logic [31:0]                       rdata;
		logic [NUM_RES-1:0]                reg_en;
		logic                              wlan_rst_n;
		logic                              bt_rst_n;
		logic                              save;
		logic                              restore;
		logic                              shutdown;
		logic [1:0]                        mode;
	} seq_state_type;

	seq_state_type cur;
	seq_state_type next_cur;

	logic                    seq_tick;
	logic [15:0]             cal_count;
	res_state_type           resource_current_state [NUM_RES];
	logic [NUM_RES-1:0]      resource_transition_pending;
	logic [NUM_RES-1:0]      start_on;
	logic [NUM_RES-1:0]      start_off;
	logic [NUM_RES-1:0]      required;
	logic [NUM_RES-1:0]      enabled_mask;
	logic [NUM_RES-1:0]      off_mask;
	logic [NUM_RES-1:0]      dependents_up;
	logic                    any_enable;

	// Decodes an indexed table address; returns hit flag and slot index
	function automatic logic [3:0] table_slot(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] delta;
		delta = addr - base;
		table_slot = {(addr >= base) && (delta < 8'(NUM_RES * 4)) && (delta[1:0] == 2'b00),
			delta[4:2]};
	endfunction

	// =====================================
	// Sequencer tick and calibration
	lpo_tick_calibrator #(
		.CAL_WIDTH (16)
	) u_tick (
		.ref_clk              (ref_clk),
		.reset_n              (reset_n),
		.low_power_oscillator (low_power_oscillator),
		.seq_tick             (seq_tick),
		.cal_count            (cal_count)
	);

	// =====================================
	// Resource slots
	// [RL6] programmable per-slot counters
	for (genvar g = 0; g < NUM_RES; g++) begin : g_slot
		resource_slot #(
			.TIMER_WIDTH (TIMER_W)
		) u_slot (
			.ref_clk   (ref_clk),
			.reset_n   (reset_n),
			.seq_tick  (seq_tick),
			.start_on  (start_on[g]),
			.start_off (start_off[g]),
			.time_on   (cur.time_on[g]),
			.time_off  (cur.time_off[g]),
			.state     (resource_current_state[g]),
			.pending   (resource_transition_pending[g])
		);
		// [RL13] slot state decoded
		assign enabled_mask[g] = (resource_current_state[g] == RES_ENABLED);
		assign off_mask[g] = (resource_current_state[g] == RES_DISABLED);
	end

	// [RL1] either enable keeps power
	assign any_enable = bt_section_power_enable || wlan_section_power_enable;

	// =====================================
	// Required set and enable/disable decisions
	always_comb begin
		required = '0;
		// [RL11] request sources
		if (any_enable) begin
			required = cur.minimum_resource_set | BUCK_MASK;
			// [RL12] clock to resources
			if (core_clk_req[0])
				required = required | XTAL_CLK_MASK;
			if (core_clk_req[1])
				required = required | PLL_CLK_MASK;
			if (cur.req_count != '0)
				required = required | cur.req_mask;
			// [RL3] baseband drives LDOs
			if (baseband_demand)
				required = required | LDO_DEMAND_MASK;
			if (cur.wake_pending)
				required = required | WAKE_MASK;
		end
		// One pass per slot, so the longest chain still closes
		// [RL17] dependency closure
		for (int k = 0; k < NUM_RES; k++) begin
			for (int i = 0; i < NUM_RES; i++) begin
				if (required[i])
					required = required | cur.dep[i];
			end
		end
		// Slots in transition count as powered up
		dependents_up = '0;
		for (int i = 0; i < NUM_RES; i++) begin
			for (int j = 0; j < NUM_RES; j++) begin
				if (cur.dep[j][i] && !off_mask[j])
					dependents_up[i] = 1'b1;
			end
		end
		// [RL20] start enable
		start_on = off_mask & required;
		for (int i = 0; i < NUM_RES; i++) begin
			if ((cur.dep[i] & ~enabled_mask) != '0)
				start_on[i] = 1'b0;
		end
		// [RL19] start disable
		start_off = enabled_mask & ~required & ~dependents_up;
		// [RL8] hold core until saved
		if (!cur.core_saved)
			start_off[RES_DIG] = 1'b0;
	end

	// =====================================
	// Registers, retention, section control
	always_comb begin
		logic [3:0] dslot;
		logic [3:0] tslot;
		dslot = table_slot(reg_addr, ADDR_DEP_BASE);
		tslot = table_slot(reg_addr, ADDR_TIME_BASE);
		next_cur = cur;
		next_cur.save = 1'b0;
		next_cur.restore = 1'b0;

		// Software writes; table entries steer the walk
		if (reg_write) begin
			if (reg_addr == ADDR_MIN_RES)
				next_cur.minimum_resource_set = reg_wdata[NUM_RES-1:0];
			if (reg_addr == ADDR_REQ_TIMER) begin
				next_cur.req_count = reg_wdata[REQ_CNT_W-1:0];
				next_cur.req_mask = reg_wdata[REQ_MASK_LSB +: NUM_RES];
			end
			if (reg_addr == ADDR_WAKE && reg_wdata[0])
				next_cur.wake_pending = 1'b0;
			if (dslot[3])
				next_cur.dep[dslot[2:0]] = reg_wdata[NUM_RES-1:0];
			if (tslot[3]) begin
				next_cur.time_on[tslot[2:0]] = reg_wdata[TIMER_W-1:0];
				next_cur.time_off[tslot[2:0]] = reg_wdata[TIME_OFF_LSB +: TIMER_W];
			end
		end else if (seq_tick && cur.req_count != '0) begin
			next_cur.req_count = cur.req_count - 1'b1;
		end

		// [RL9] wake sources, set beats clear
		if (ext_wake_irq || sdio_resume ||
			(seq_tick && !reg_write && cur.req_count == 16'h0001))
			next_cur.wake_pending = 1'b1;

		// Save gets a tick to itself; the core drops on a later tick
		// [RL8] save before core off
		if (seq_tick && enabled_mask[RES_DIG] && !required[RES_DIG] &&
			!dependents_up[RES_DIG] && !cur.core_saved) begin
			next_cur.core_saved = 1'b1;
			next_cur.save = 1'b1;
		end
		// [RL9] restore after core returns
		if (enabled_mask[RES_DIG] && cur.core_saved && required[RES_DIG]) begin
			next_cur.core_saved = 1'b0;
			next_cur.restore = 1'b1;
		end
		// [RL22] saved-core flag cleared across power-down; register settings kept
		if (!any_enable && off_mask[RES_DIG])
			next_cur.core_saved = 1'b0;

		// Read data for the following cycle; unmapped reads zero
		next_cur.rdata = '0;
		if (reg_read) begin
			case (reg_addr)
				ADDR_MIN_RES:   next_cur.rdata[NUM_RES-1:0] = cur.minimum_resource_set;
				ADDR_STATE:     next_cur.rdata[NUM_RES-1:0] = enabled_mask;
				ADDR_PENDING:   next_cur.rdata[NUM_RES-1:0] = resource_transition_pending;
				ADDR_REQ_TIMER: next_cur.rdata = {8'h00, cur.req_mask, cur.req_count};
				ADDR_CAL:       next_cur.rdata[15:0] = cal_count;
				ADDR_WAKE:      next_cur.rdata[0] = cur.wake_pending;
				default: begin
					if (dslot[3])
						next_cur.rdata[NUM_RES-1:0] = cur.dep[dslot[2:0]];
					else if (tslot[3])
						next_cur.rdata[15:0] = {cur.time_off[tslot[2:0]],
							cur.time_on[tslot[2:0]]};
				end
			endcase
		end

		// [RL4] outputs follow slot power, always-on LDO not modelled here
		next_cur.reg_en = ~off_mask;
		// [RL2] release only once buck is up
		// [RL24] low enable holds reset
		next_cur.wlan_rst_n = wlan_section_power_enable && enabled_mask[RES_BUCK];
		next_cur.bt_rst_n = bt_section_power_enable && enabled_mask[RES_BUCK];
		// [RL21] shutdown once both section enables are low and everything is off
		next_cur.shutdown = !any_enable && (off_mask == '1);

		// [RL7] doze: core alive, clocks and radio down
		if (off_mask == '1)
			next_cur.mode = MODE_POWER_DOWN;
		else if (!enabled_mask[RES_DIG])
			next_cur.mode = MODE_DEEP_SLEEP;
		else if (off_mask[RES_PLL] && off_mask[RES_XTAL] && off_mask[RES_RADIO])
			next_cur.mode = MODE_DOZE;
		else
			next_cur.mode = MODE_ACTIVE;
	end

	// [RL23] defined reset state
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
			cur.minimum_resource_set <= MIN_RES_RESET;
			cur.dep <= DEP_RESET;
			cur.time_on <= {NUM_RES{TIME_RESET}};
			cur.time_off <= {NUM_RES{TIME_RESET}};
			cur.mode <= MODE_POWER_DOWN;
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_rdata            = cur.rdata;
	assign regulator_enable     = cur.reg_en;
	assign wlan_section_reset_n = cur.wlan_rst_n;
	assign bt_section_reset_n   = cur.bt_rst_n;
	assign retention_save       = cur.save;
	assign retention_restore    = cur.restore;
	assign io_shutdown          = cur.shutdown;
	assign power_mode           = cur.mode;

	// =====================================
	// Checks
	AST_BUCK_HELD: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL1]
		(any_enable && enabled_mask[RES_BUCK]) ##1 any_enable |-> enabled_mask[RES_BUCK])
		else $error("buck dropped while a section enable is high");
	AST_SHUTDOWN_ALL_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL21]
		io_shutdown |-> (regulator_enable == '0 && !$past(any_enable)))
		else $error("shutdown flagged with power still up");
	AST_WLAN_RESET: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL24]
		!wlan_section_power_enable |=> !wlan_section_reset_n)
		else $error("wlan section left out of reset");
	AST_SAVE_FIRST: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL8]
		(seq_tick && start_off[RES_DIG]) |-> (cur.core_saved && !retention_save))
		else $error("core powered off before save");
	AST_RESTORE_ON_RETURN: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL9]
		(enabled_mask[RES_DIG] && cur.core_saved && required[RES_DIG]) |=>
		(retention_restore && !cur.core_saved))
		else $error("restore missing after core return");
	AST_ON_NEEDS_DEPS: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL20]
		(seq_tick && start_on[RES_PLL]) |-> !(cur.dep[RES_PLL][RES_XTAL] && !enabled_mask[RES_XTAL]))
		else $error("enable started with dependency down");
	AST_TIMER_WAKE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL9]
		(seq_tick && !reg_write && cur.req_count == 16'h0001) |=> cur.wake_pending)
		else $error("request timer expiry did not wake");
	AST_EMPTY_WHEN_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL1]
		!any_enable |-> (required == '0 && start_on == '0))
		else $error("resource requested with both enables low");

	AST_BT_RELEASE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL2]
		(bt_section_power_enable && enabled_mask[RES_BUCK]) |=> bt_section_reset_n)
		else $error("bt section not released");

	AST_ONE_STATE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL13]
		(resource_transition_pending & (enabled_mask | off_mask)) == '0)
		else $error("slot in two states");

	AST_REG_EN_TRACKS: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL4]
		regulator_enable == ~$past(off_mask))
		else $error("regulator enable off track");

	COV_DEEP_SLEEP: cover property (@(posedge ref_clk) disable iff (!reset_n)
		power_mode == MODE_DEEP_SLEEP);
	COV_RESTORE: cover property (@(posedge ref_clk) disable iff (!reset_n) retention_restore);
	COV_SHUTDOWN: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(io_shutdown));

	COV_DOZE: cover property (@(posedge ref_clk) disable iff (!reset_n) power_mode == MODE_DOZE);
	COV_SAVE: cover property (@(posedge ref_clk) disable iff (!reset_n) retention_save);
endmodule // pmu_resource_sequencer

//--- design/pmu_seq_pkg.sv
package pmu_seq_pkg;
	// =====================================
	// Resource slots
	localparam int NUM_RES  = 8;
	localparam int TIMER_W  = 8;
	localparam int REQ_CNT_W = 16;
	localparam int RES_BUCK  = 0;
	localparam int RES_CORE_LINEAR_REGULATOR  = 1;
	localparam int RES_LOW_NOISE_LINEAR_REGULATOR = 2;
	localparam int RES_XTAL  = 3;
	localparam int RES_PLL   = 4;
	localparam int RES_RADIO = 5;
	localparam int RES_DIG   = 6;
	localparam int RES_SPARE = 7;

	typedef enum logic [1:0] {
		RES_DISABLED,
		RES_TURNING_ON,
		RES_ENABLED,
		RES_TURNING_OFF
	} res_state_type;

	typedef enum logic [1:0] {
		MODE_POWER_DOWN,
		MODE_DEEP_SLEEP,
		MODE_DOZE,
		MODE_ACTIVE
	} mode_type;

	// =====================================
	// Register map, byte addresses
	localparam logic [7:0] ADDR_MIN_RES   = 8'h00;
	localparam logic [7:0] ADDR_STATE     = 8'h04;
	localparam logic [7:0] ADDR_PENDING   = 8'h08;
	localparam logic [7:0] ADDR_REQ_TIMER = 8'h0C;
	localparam logic [7:0] ADDR_CAL       = 8'h10;
	localparam logic [7:0] ADDR_WAKE      = 8'h14;
	localparam logic [7:0] ADDR_DEP_BASE  = 8'h40;
	localparam logic [7:0] ADDR_TIME_BASE = 8'h80;

	// =====================================
	// Field layouts and reset values
	localparam int REQ_MASK_LSB = 16;
	localparam int TIME_OFF_LSB = 8;
	localparam logic [NUM_RES-1:0] MIN_RES_RESET   = 8'h00;
	localparam logic [TIMER_W-1:0] TIME_RESET      = 8'h02;
	localparam logic [NUM_RES-1:0] BUCK_MASK       = 8'h01;
	localparam logic [NUM_RES-1:0] LDO_DEMAND_MASK = 8'h06;
	localparam logic [NUM_RES-1:0] XTAL_CLK_MASK   = 8'h08;
	localparam logic [NUM_RES-1:0] PLL_CLK_MASK    = 8'h10;
	localparam logic [NUM_RES-1:0] WAKE_MASK       = 8'h40;
	// Each entry lists the resources that slot needs already enabled
	localparam logic [NUM_RES-1:0][NUM_RES-1:0] DEP_RESET = {
		8'h00, 8'h02, 8'h14, 8'h08, 8'h01, 8'h01, 8'h01, 8'h00};
endpackage

//--- design/resource_slot.sv
`timescale 1ns/1ps
module resource_slot
	import pmu_seq_pkg::*;
#(
	parameter int TIMER_WIDTH = TIMER_W
) (
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   seq_tick,
	input  wire logic                   start_on,
	input  wire logic                   start_off,
	input  wire logic [TIMER_WIDTH-1:0] time_on,
	input  wire logic [TIMER_WIDTH-1:0] time_off,
	output res_state_type               state,
	output logic                        pending
);
	typedef struct packed {
		res_state_type          state;
		logic [TIMER_WIDTH-1:0] timer;
	} slot_type;

	slot_type cur;
	slot_type next_cur;

	// =====================================
	// Transition walk, one step per sequencer tick
	always_comb begin
		next_cur = cur;
		if (seq_tick) begin
			case (cur.state)
				// [RL16] zero time skips
				RES_DISABLED: if (start_on) begin
					next_cur.timer = time_on;
					next_cur.state = (time_on == '0) ? RES_ENABLED : RES_TURNING_ON;
				end
				RES_ENABLED: if (start_off) begin
					next_cur.timer = time_off;
					next_cur.state = (time_off == '0) ? RES_DISABLED : RES_TURNING_OFF;
				end
				// [RL15] countdown to done
				RES_TURNING_ON: begin
					next_cur.timer = cur.timer - 1'b1;
					if (cur.timer == {{(TIMER_WIDTH-1){1'b0}}, 1'b1})
						next_cur.state = RES_ENABLED;
				end
				RES_TURNING_OFF: begin
					next_cur.timer = cur.timer - 1'b1;
					if (cur.timer == {{(TIMER_WIDTH-1){1'b0}}, 1'b1})
						next_cur.state = RES_DISABLED;
				end
				default: next_cur = '0;
			endcase
		end
	end

	// [RL23] reset to disabled
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign state = cur.state;
	// [RL18] pending drops with flip
	assign pending = (cur.state == RES_TURNING_ON) || (cur.state == RES_TURNING_OFF);

	AST_TIMER_ZERO_STABLE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL14]
		((cur.state == RES_ENABLED || cur.state == RES_DISABLED) == (cur.timer == '0)))
		else $error("timer and stable state disagree");
	AST_ON_COMPLETES: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL15]
		(seq_tick && cur.state == RES_TURNING_ON && cur.timer == 1) |=>
		(cur.state == RES_ENABLED && !pending))
		else $error("turn-on did not complete at zero");
	AST_ZERO_OFF_DIRECT: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL16]
		(seq_tick && cur.state == RES_ENABLED && start_off && time_off == '0) |=>
		cur.state == RES_DISABLED)
		else $error("zero turn-off time not immediate");
endmodule // resource_slot

//--- sim/host_enable_model.sv
`timescale 1ns/1ps
// =====================================
// Host side of the two section enables
module host_enable_model (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic bt_want,
	input  wire logic wlan_want,
	output logic      bt_section_power_enable,
	output logic      wlan_section_power_enable
);
	// Host drives enables as synchronous levels, never mid-cycle
	// re-enable leaves power-down
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bt_section_power_enable   <= 1'b0;
			wlan_section_power_enable <= 1'b0;
		end else begin
			bt_section_power_enable   <= bt_want;
			wlan_section_power_enable <= wlan_want;
		end
	end
endmodule // host_enable_model

//--- sim/pmu_resource_sequencer_tb.sv
`timescale 1ns/1ps
module pmu_resource_sequencer_tb
	import pmu_seq_pkg::*;
;
	// =====================================
	// Signals
	logic               ref_clk, reset_n, bt_want, wlan_want, bt_en, wlan_en, lpo;
	logic               baseband_demand, ext_wake_irq, sdio_resume, reg_write, reg_read;
	logic               wlan_rst_n, bt_rst_n, retention_save, retention_restore, io_shutdown;
	logic               save_core;
	logic [1:0]         core_clk_req, power_mode;
	logic [2:0]         lpo_div;
	logic [7:0]         reg_addr;
	logic [31:0]        reg_wdata, reg_rdata, rd_data;
	logic [NUM_RES-1:0] regulator_enable;
	logic [15:0]        save_count, restore_count;
	int                 fails, check_count;

	host_enable_model i_host (.ref_clk(ref_clk), .reset_n(reset_n), .bt_want(bt_want),
		.wlan_want(wlan_want), .bt_section_power_enable(bt_en),
		.wlan_section_power_enable(wlan_en));

	pmu_resource_sequencer i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.bt_section_power_enable(bt_en), .wlan_section_power_enable(wlan_en),
		.low_power_oscillator(lpo), .core_clk_req(core_clk_req),
		.baseband_demand(baseband_demand), .ext_wake_irq(ext_wake_irq),
		.sdio_resume(sdio_resume), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.regulator_enable(regulator_enable), .wlan_section_reset_n(wlan_rst_n),
		.bt_section_reset_n(bt_rst_n), .retention_save(retention_save),
		.retention_restore(retention_restore), .io_shutdown(io_shutdown),
		.power_mode(power_mode));

	// =====================================
	// Clocks and monitors
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Oscillator sped up to 16 ref_clk cycles a period to keep the run short
	always @(posedge ref_clk) begin
		lpo_div <= lpo_div + 3'h1;
		if (lpo_div == 3'h7) lpo <= ~lpo;
	end

	// Note whether the core was still powered when its state was saved
	always @(posedge ref_clk) begin
		if (retention_save) begin
			save_count <= save_count + 16'h0001;
			save_core  <= regulator_enable[RES_DIG];
		end
		if (retention_restore) restore_count <= restore_count + 16'h0001;
	end

	// =====================================
	// Shared tasks
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 rd_data = reg_rdata;
	endtask

	// Bounded wait on one regulator output
	task automatic wait_res(input int idx, input logic val);
		int n;
		n = 0;
		#1;
		while (regulator_enable[idx] !== val && n < 2000) begin
			settle(1);
			n++;
		end
		chk("regulator wait", {15'h0000, val}, {15'h0000, regulator_enable[idx]});
	endtask

	task automatic set_in(input logic [1:0] clk_req, input logic dem, input logic irq,
			input logic res);
		@(posedge ref_clk);
		core_clk_req    <= clk_req;
		baseband_demand <= dem;
		ext_wake_irq    <= irq;
		sdio_resume     <= res;
	endtask

	// =====================================
	// Scenarios
	task automatic t_reset;
		settle(4);
		chk("regulators", 16'h0000, {8'h00, regulator_enable});
		chk("shutdown", 16'h0001, {15'h0000, io_shutdown});
		chk("mode", 16'h0000, {14'h0000, power_mode});
		rd(ADDR_MIN_RES);
		chk("min set", 16'h0000, rd_data[15:0]);
		rd(ADDR_TIME_BASE);
		chk("buck times", 16'h0202, rd_data[15:0]);
		rd(ADDR_DEP_BASE + 8'h14);
		chk("radio deps", 16'h0014, rd_data[15:0]);
		rd(8'h3C);
		chk("unmapped", 16'h0000, rd_data[15:0]);
	endtask

	task automatic t_power_up;
		@(posedge ref_clk);
		wlan_want <= 1'b1;
		wait_res(RES_BUCK, 1'b1);
		rd(ADDR_PENDING);
		chk("buck pending", 16'h0001, rd_data[15:0] & 16'h0001);
		rd(ADDR_STATE);
		chk("buck midway", 16'h0000, rd_data[15:0] & 16'h0001);
		settle(48);
		chk("wlan out of reset", 16'h0001, {15'h0000, wlan_rst_n});
		chk("bt held", 16'h0000, {15'h0000, bt_rst_n});
		chk("awake", 16'h0000, {15'h0000, io_shutdown});
		rd(ADDR_PENDING);
		chk("pending cleared", 16'h0000, rd_data[15:0]);
		rd(ADDR_CAL);
		chk("calibration", 16'h0010, rd_data[15:0]);
	endtask

	task automatic t_demand;
		set_in(2'b00, 1'b1, 1'b0, 1'b0);
		wait_res(RES_LOW_NOISE_LINEAR_REGULATOR, 1'b1);
		settle(48);
		rd(ADDR_STATE);
		chk("ldo state", 16'h0007, rd_data[15:0]);
		set_in(2'b00, 1'b0, 1'b0, 1'b0);
		wait_res(RES_CORE_LINEAR_REGULATOR, 1'b0);
		wait_res(RES_LOW_NOISE_LINEAR_REGULATOR, 1'b0);
	endtask

	task automatic t_clocks;
		set_in(2'b10, 1'b0, 1'b0, 1'b0);
		wait_res(RES_PLL, 1'b1);
		rd(ADDR_STATE);
		chk("crystal first", 16'h0008, rd_data[15:0] & 16'h0008);
		settle(48);
		set_in(2'b00, 1'b0, 1'b0, 1'b0);
		wait_res(RES_XTAL, 1'b0);
		chk("pll before crystal", 16'h0000, {15'h0000, regulator_enable[RES_PLL]});
		wr(ADDR_TIME_BASE + 8'h0C, 32'h0000_0000);
		set_in(2'b01, 1'b0, 1'b0, 1'b0);
		wait_res(RES_XTAL, 1'b1);
		rd(ADDR_PENDING);
		chk("no crystal delay", 16'h0000, rd_data[15:0] & 16'h0008);
		set_in(2'b00, 1'b0, 1'b0, 1'b0);
		wait_res(RES_XTAL, 1'b0);
	endtask

	task automatic t_sleep;
		set_in(2'b00, 1'b0, 1'b1, 1'b0);
		set_in(2'b00, 1'b0, 1'b0, 1'b0);
		wait_res(RES_DIG, 1'b1);
		settle(48);
		chk("doze", 16'h0002, {14'h0000, power_mode});
		wr(ADDR_WAKE, 32'h0000_0001);
		wait_res(RES_DIG, 1'b0);
		chk("deep sleep", 16'h0001, {14'h0000, power_mode});
		chk("saved", 16'h0001, save_count);
		chk("saved with core up", 16'h0001, {15'h0000, save_core});
		set_in(2'b01, 1'b0, 1'b0, 1'b1);
		set_in(2'b01, 1'b0, 1'b0, 1'b0);
		wait_res(RES_DIG, 1'b1);
		settle(48);
		chk("restored", 16'h0001, restore_count);
		chk("active", 16'h0003, {14'h0000, power_mode});
		set_in(2'b00, 1'b0, 1'b0, 1'b0);
		wr(ADDR_WAKE, 32'h0000_0001);
		wait_res(RES_DIG, 1'b0);
		wr(ADDR_REQ_TIMER, 32'h0080_0004);
		wait_res(RES_SPARE, 1'b1);
		wait_res(RES_SPARE, 1'b0);
		wait_res(RES_DIG, 1'b1);
		settle(48);
		chk("timer wake restore", 16'h0002, restore_count);
		wr(ADDR_WAKE, 32'h0000_0001);
		wait_res(RES_DIG, 1'b0);
	endtask

	task automatic t_shutdown;
		@(posedge ref_clk);
		wlan_want <= 1'b0;
		wait_res(RES_BUCK, 1'b0);
		settle(4);
		chk("all off", 16'h0000, {8'h00, regulator_enable});
		chk("io off", 16'h0001, {15'h0000, io_shutdown});
		chk("wlan held", 16'h0000, {15'h0000, wlan_rst_n});
		@(posedge ref_clk);
		bt_want <= 1'b1;
		wait_res(RES_BUCK, 1'b1);
		settle(48);
		chk("bt released", 16'h0001, {15'h0000, bt_rst_n});
	endtask

	// =====================================
	// Verdict and sequence
	task automatic stop_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		{reset_n, bt_want, wlan_want, lpo, baseband_demand, ext_wake_irq} = '0;
		{sdio_resume, reg_write, reg_read, save_core} = '0;
		{core_clk_req, lpo_div, reg_addr, reg_wdata} = '0;
		{save_count, restore_count, fails, check_count} = '0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_power_up();
		t_demand();
		t_clocks();
		t_sleep();
		t_shutdown();
		stop_test();
	end

	// Watchdog well beyond the longest expected run
	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		stop_test();
	end
endmodule // pmu_resource_sequencer_tb
